/* design/tgcw_pkg.sv */
package tgcw_pkg;

    // ------------------------------------------------------------
    // Control word location and layout
    // ------------------------------------------------------------
    localparam logic [15:0] TGCW_WORD_PTR = 16'h9e00;      // User-bank word pointer
    localparam logic [15:0] TGCW_RESET_VALUE = 16'h0000;   // After power loss or brown-out
    localparam int TGCW_NUM_OUT = 3;                       // Output pins
    localparam int TGCW_IN_EN_BIT = 15;                    // Input pin function enable
    localparam int TGCW_OUT_EN_LSB = 12;                   // Output enables 14:12
    localparam int TGCW_RSVD_LSB = 8;                      // Reserved 11:8
    localparam int TGCW_RSVD_MSB = 11;
    localparam int TGCW_IN_MASK_BIT = 7;                   // Update mask for input pin
    localparam int TGCW_OUT_MASK_LSB = 4;                  // Update masks 6:4
    localparam int TGCW_IN_DATA_BIT = 3;                   // Input data bit
    localparam int TGCW_OUT_DATA_LSB = 0;                  // Output data 2:0

    // ------------------------------------------------------------
    // Command port carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic write;          // Write command strobe
        logic read;           // Read command strobe
        logic [15:0] addr;    // Word pointer
        logic [15:0] data;    // Write data
    } tgcw_cmd_s;

    typedef struct packed {
        logic valid;          // Answer strobe
        logic hit;            // Command addressed the control word
        logic [15:0] data;    // Read data, zero for writes and misses
    } tgcw_rsp_s;

    // Command sequencer states
    typedef enum logic [2:0] {
        TGCW_IDLE = 3'b001,
        TGCW_WRITE = 3'b010,
        TGCW_READ = 3'b100
    } tgcw_state_e;

endpackage

/* design/tgcw_out_cell.sv */
`timescale 1ns/1ps

// One three-state output pin with its enable and stored level
module tgcw_out_cell (
    input wire logic refClk,     // Tag clock
    input wire logic clear,      // Synchronous clear to reset value
    input wire logic wrStb,      // Apply a write this cycle
    input wire logic maskBit,    // Update mask for this pin
    input wire logic enBit,      // Written function enable
    input wire logic datBit,     // Written output data
    output logic fnEn,           // Stored function enable
    output logic readBit,        // Data bit as returned on read
    output logic pinOut,         // Pin level
    output logic pinOeN          // Pin enable, low while driving
);

    logic enReg, enNext;
    logic datReg, datNext;
    logic pinReg, pinNext;
    logic oeNReg, oeNNext;

    // ------------------------------------------------------------
    // Next state of enable, data and pin
    // ------------------------------------------------------------
    always_comb begin
        enNext = enReg;
        datNext = datReg;
        if (wrStb && maskBit) begin
            enNext = enBit;                        // [R09]
            datNext = enBit ? datBit : 1'b0;       // Data is don't-care when disabled [R11]
        end                                        // Mask clear keeps both [R08]
        pinNext = enNext & datNext;                // [R07]
        oeNNext = ~enNext;                         // Hi-Z while disabled [R06]
    end

    // Registers only
    always_ff @(posedge refClk) begin
        if (clear) begin
            enReg <= 1'b0;
            datReg <= 1'b0;
            pinReg <= 1'b0;
            oeNReg <= 1'b1;
        end else begin
            enReg <= enNext;
            datReg <= datNext;
            pinReg <= pinNext;
            oeNReg <= oeNNext;
        end
    end

    assign fnEn = enReg;
    assign readBit = enReg & datReg;               // Zero while disabled [R06] [R07]
    assign pinOut = pinReg;
    assign pinOeN = oeNReg;

endmodule

/* design/tgcw_in_cell.sv */
`timescale 1ns/1ps

// External input pin gate with a software test value
module tgcw_in_cell (
    input wire logic refClk,     // Tag clock
    input wire logic clear,      // Synchronous clear to reset value
    input wire logic wrStb,      // Apply a write this cycle
    input wire logic maskBit,    // Update mask for the input pin
    input wire logic enBit,      // Written function enable
    input wire logic datBit,     // Written test value
    input wire logic pinIn,      // External input level
    output logic fnEn,           // Stored function enable
    output logic readBit         // Bit as returned on read
);

    logic enReg, enNext;
    logic datReg, datNext;
    logic pinReg;

    // ------------------------------------------------------------
    // Enable and test value update
    // ------------------------------------------------------------
    always_comb begin
        enNext = enReg;
        datNext = datReg;
        if (wrStb && maskBit) begin
            enNext = enBit;                        // [R09]
            if (!enBit) begin
                datNext = datBit;                  // Test value only when gated off [R04]
            end                                    // Written value ignored when enabled [R10]
        end                                        // Mask clear keeps both [R08]
    end

    // Registers; pin sampled every cycle, inputs are synchronous
    always_ff @(posedge refClk) begin
        if (clear) begin
            enReg <= 1'b0;
            datReg <= 1'b0;
            pinReg <= 1'b0;
        end else begin
            enReg <= enNext;
            datReg <= datNext;
            pinReg <= pinIn;
        end
    end

    assign fnEn = enReg;
    assign readBit = enReg ? pinReg : datReg;      // [R05] [R04]

endmodule

/* design/tgcw_control_word.sv */
// Summary of operation
// R01 - Bits 11 to 8 of the control word always read as zero.
// R02 - The update-mask field, bits 7 to 4, always reads as zero and is never stored.
// R03 - On a write the update-mask bits pick which pin enables and data bits are loaded.
// R04 - With the input pin gated off, bit 3 reads back the value last written as a test value.
// R05 - With the input pin enabled, bit 3 reads the live level of the external input pin.
// R06 - A disabled output pin stays high-impedance and its data bit reads zero.
// R07 - An enabled output pin drives its stored level and reads back that level.
// R08 - A clear update-mask bit leaves that pin's enable and data unchanged.
// R09 - A set update-mask bit loads that pin's enable and data from the written word.
// R10 - With the input pin enabled, the written input data is disregarded.
// R11 - Don't-care written fields affect neither stored state nor read value.
// R12 - The word is reached by Read and Write at one fixed location and clears to zero on reset.
// R13 - Bit 15 enables the input pin, bits 14 to 12 enable output pins 2 to 0, 7 to 4 are masks.
`timescale 1ns/1ps

module tgcw_control_word
    import tgcw_pkg::*;
#(
    parameter int NUM_OUT = TGCW_NUM_OUT       // Number of output pins
) (
    input wire logic ref_clk,                  // Tag clock, 25 MHz
    input wire logic srst,                     // Synchronous reset, active high
    input wire logic lowVoltRst,               // Brown-out reset from power monitor
    input wire tgcw_cmd_s cmdIn,               // Read and Write commands
    input wire logic intPin,                   // External input pin level
    output tgcw_rsp_s rspOut,                  // Command answer
    output logic cmdBusy,                      // High while a command is in progress
    output logic [NUM_OUT-1:0] comOut,         // Output pin levels
    output logic [NUM_OUT-1:0] comOeN,         // Output pin enables, low while driving
    output logic inputEnabled                  // Input pin function enable state
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    tgcw_state_e stateReg, stateNext;
    logic [15:0] wrDataReg, wrDataNext;
    logic hitReg, hitNext;
    tgcw_rsp_s rspReg, rspNext;
    logic busyReg, busyNext;
    logic inEnOutReg;
    logic clear;
    logic wrStb;
    logic cmdHit;
    logic [NUM_OUT-1:0] outFnEn;
    logic [NUM_OUT-1:0] outReadBit;
    logic inFnEn;
    logic inReadBit;
    logic [15:0] readWord;

    // Power loss and brown-out both return the word to its reset value
    assign clear = srst | lowVoltRst;                            // [R12]

    // Only the fixed word location is decoded
    assign cmdHit = (cmdIn.addr == TGCW_WORD_PTR);               // [R12]

    // Apply the captured write while in the write state
    assign wrStb = (stateReg == TGCW_WRITE) && hitReg;           // [R03]

    // ------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------
    // Commands arriving while busy are dropped; the reader side
    // never issues back-to-back commands faster than one per answer.
    always_comb begin
        stateNext = stateReg;
        wrDataNext = wrDataReg;
        hitNext = hitReg;
        rspNext = '0;
        busyNext = busyReg;
        case (stateReg)
            TGCW_IDLE: begin
                if (cmdIn.write) begin
                    stateNext = TGCW_WRITE;
                    wrDataNext = cmdIn.data;
                    hitNext = cmdHit;
                    busyNext = 1'b1;
                end else if (cmdIn.read) begin
                    stateNext = TGCW_READ;
                    hitNext = cmdHit;
                    busyNext = 1'b1;
                end
            end
            TGCW_WRITE: begin
                rspNext.valid = 1'b1;
                rspNext.hit = hitReg;
                stateNext = TGCW_IDLE;
                busyNext = 1'b0;
            end
            TGCW_READ: begin
                rspNext.valid = 1'b1;
                rspNext.hit = hitReg;
                rspNext.data = hitReg ? readWord : 16'h0000;
                stateNext = TGCW_IDLE;
                busyNext = 1'b0;
            end
            default: begin
                stateNext = TGCW_IDLE;
                busyNext = 1'b0;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge ref_clk) begin
        if (clear) begin
            stateReg <= TGCW_IDLE;
            wrDataReg <= TGCW_RESET_VALUE;
            hitReg <= 1'b0;
            rspReg <= '0;
            busyReg <= 1'b0;
            inEnOutReg <= 1'b0;
        end else begin
            stateReg <= stateNext;
            wrDataReg <= wrDataNext;
            hitReg <= hitNext;
            rspReg <= rspNext;
            busyReg <= busyNext;
            inEnOutReg <= inFnEn;
        end
    end

    // ------------------------------------------------------------
    // Input pin
    // ------------------------------------------------------------
    tgcw_in_cell u_in (
        .refClk(ref_clk),
        .clear(clear),
        .wrStb(wrStb),
        .maskBit(wrDataReg[TGCW_IN_MASK_BIT]),                   // [R13]
        .enBit(wrDataReg[TGCW_IN_EN_BIT]),                       // [R13]
        .datBit(wrDataReg[TGCW_IN_DATA_BIT]),
        .pinIn(intPin),
        .fnEn(inFnEn),
        .readBit(inReadBit)
    );

    // ------------------------------------------------------------
    // Output pins
    // ------------------------------------------------------------
    for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
        tgcw_out_cell u_out (
            .refClk(ref_clk),
            .clear(clear),
            .wrStb(wrStb),
            .maskBit(wrDataReg[TGCW_OUT_MASK_LSB + i]),          // [R13]
            .enBit(wrDataReg[TGCW_OUT_EN_LSB + i]),              // [R13]
            .datBit(wrDataReg[TGCW_OUT_DATA_LSB + i]),
            .fnEn(outFnEn[i]),
            .readBit(outReadBit[i]),
            .pinOut(comOut[i]),
            .pinOeN(comOeN[i])
        );
    end

    // ------------------------------------------------------------
    // Read word assembly
    // ------------------------------------------------------------
    // Masks and reserved field are never stored, so they read zero
    always_comb begin
        readWord = 16'h0000;                                     // [R01] [R02]
        readWord[TGCW_IN_EN_BIT] = inFnEn;
        readWord[TGCW_IN_DATA_BIT] = inReadBit;                  // [R04] [R05]
        for (int k = 0; k < NUM_OUT; k++) begin
            readWord[TGCW_OUT_EN_LSB + k] = outFnEn[k];
            readWord[TGCW_OUT_DATA_LSB + k] = outReadBit[k];     // [R06] [R07]
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rspOut = rspReg;
    assign cmdBusy = busyReg;
    assign inputEnabled = inEnOutReg;

endmodule

/* tb/tgcw_control_word_checker.sv */
`timescale 1ns/1ps
module tgcw_control_word_checker
    import tgcw_pkg::*;
#(
    parameter int NUM_OUT = TGCW_NUM_OUT // Output pins
) (
    input wire logic ref_clk, // Clock
    input wire logic srst, // Reset
    input wire logic lowVoltRst, // Brown-out
    input wire tgcw_cmd_s cmdIn, // Commands
    input wire logic intPin, // Input pin
    input wire tgcw_rsp_s rspOut, // Answers
    input wire logic cmdBusy, // Busy
    input wire logic [NUM_OUT-1:0] comOut, // Levels
    input wire logic [NUM_OUT-1:0] comOeN, // Enables
    input wire logic inputEnabled // Input enable
);
    // ----
    // Command timing and pin state
    // ----
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst || lowVoltRst);
    logic taken;
    logic isRd;
    logic [15:0] d1;
    logic [15:0] d2;
    // Write data delayed to the cycle the pins change
    always_ff @(posedge ref_clk) begin
        d1 <= cmdIn.data;
        d2 <= d1;
    end
    assign taken = !cmdBusy && (cmdIn.write || cmdIn.read);
    assign isRd = taken && !cmdIn.write;
    sequence busyOnce;
        cmdBusy ##1 !cmdBusy;
    endsequence
    sequence hitReadAns;
        $past(isRd, 2) && rspOut.valid && rspOut.hit;
    endsequence
    chk_answer_two: assert property (taken |-> ##2 rspOut.valid)
        else $error("answer not two cycles after command");
    chk_busy_one: assert property (taken |=> busyOnce)
        else $error("busy not a single cycle");
    chk_rsvd_zero: assert property (rspOut.valid |-> rspOut.data[11:4] == 8'h00)
        else $error("reserved or mask field not zero");
    chk_miss_zero: assert property (rspOut.valid && !rspOut.hit |-> rspOut.data == 16'h0000)
        else $error("miss returned data");
    chk_pin_read: assert property (hitReadAns |->
        rspOut.data[12 +: NUM_OUT] == ~comOeN && rspOut.data[0 +: NUM_OUT] == (comOut & ~comOeN)
        && rspOut.data[15] == inputEnabled)
        else $error("read word disagrees with pins");
    chk_hiz_low: assert property ((comOut & comOeN) == '0)
        else $error("released pin shows high level");
    chk_mask_hold: assert property (taken && cmdIn.write && cmdIn.data[6:4] == 3'b000
        |=> ##1 $stable(comOut) && $stable(comOeN))
        else $error("unmasked write changed pins");
    chk_mask_load: assert property (taken && cmdIn.write
        && cmdIn.addr == TGCW_WORD_PTR && cmdIn.data[6:4] == 3'b111
        |-> ##2 comOeN == ~d2[12 +: NUM_OUT]
        && comOut == (d2[0 +: NUM_OUT] & d2[12 +: NUM_OUT]))
        else $error("masked write not loaded");
endmodule

bind tgcw_control_word tgcw_control_word_checker #(.NUM_OUT(NUM_OUT)) i_tgcw_control_word_checker (
    .ref_clk(ref_clk), .srst(srst), .lowVoltRst(lowVoltRst), .cmdIn(cmdIn), .intPin(intPin),
    .rspOut(rspOut), .cmdBusy(cmdBusy), .comOut(comOut), .comOeN(comOeN),
    .inputEnabled(inputEnabled));

/* tb/tgcw_reader_model.sv */
`timescale 1ns/1ps
module tgcw_reader_model
    import tgcw_pkg::*;
(
    input wire logic ref_clk, // Clock
    input wire logic cmdBusy, // Device busy
    input wire tgcw_rsp_s rspOut, // Answers
    output tgcw_cmd_s cmdIn // Commands
);
    // ----
    // One Read or Write command, gap gives a slow reader
    // ----
    initial cmdIn = '0;
    task automatic access(input logic wr, input logic [15:0] addr, input logic [15:0] data,
                          input int gap, output logic [15:0] rdata, output logic hit);
        int n;
        n = 0;
        rdata = 'x;
        hit = 1'bx;
        repeat (gap + 1) @(posedge ref_clk);
        #1;
        while (cmdBusy && n < 8) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        cmdIn = '{write: wr, read: !wr, addr: addr, data: data};
        @(posedge ref_clk);
        // Idle fields invert so a stale word is never mistaken for live
        #1 cmdIn = '{write: 1'b0, read: 1'b0, addr: ~addr, data: ~data};
        // Look just after each edge, once the registered answer has settled
        for (n = 0; n < 6; n++) begin
            @(posedge ref_clk);
            #1;
            if (rspOut.valid === 1'b1) begin
                rdata = rspOut.data;
                hit = rspOut.hit;
                break;
            end
        end
    endtask
endmodule

/* tb/tgcw_control_word_tb_top.sv */
`timescale 1ns/1ps
module tgcw_control_word_tb_top
    import tgcw_pkg::*;
();
    // ----
    // Bench
    // ----
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic lowVoltRst = 1'b0;
    logic intPin = 1'b0;
    tgcw_cmd_s cmdIn;
    tgcw_rsp_s rspOut;
    logic cmdBusy;
    logic [2:0] comOut;
    logic [2:0] comOeN;
    logic inputEnabled;
    logic [15:0] rdata;
    logic hit;
    logic [3:0] enS = 4'h0; // Expected enables, input pin at bit 3
    logic [3:0] datS = 4'h0; // Expected stored data
    int failCount = 0;
    int checks = 0;
    always #20 ref_clk = ~ref_clk;
    tgcw_control_word #(.NUM_OUT(3)) i_tgcw_control_word (.ref_clk(ref_clk), .srst(srst),
        .lowVoltRst(lowVoltRst), .cmdIn(cmdIn), .intPin(intPin), .rspOut(rspOut),
        .cmdBusy(cmdBusy), .comOut(comOut), .comOeN(comOeN), .inputEnabled(inputEnabled));
    tgcw_reader_model i_tgcw_reader_model (.ref_clk(ref_clk), .cmdBusy(cmdBusy),
        .rspOut(rspOut), .cmdIn(cmdIn));
    task automatic expect16(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            failCount++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Write the word and follow the masks in the expected state
    task automatic wr(input logic [15:0] d);
        i_tgcw_reader_model.access(1'b1, TGCW_WORD_PTR, d, 0, rdata, hit);
        expect16({15'h0, hit}, 16'h0001);
        for (int i = 0; i < 4; i++) begin
            if (d[4 + i]) begin
                enS[i] = d[12 + i];
                datS[i] = d[i];
            end
        end
    endtask
    task automatic rdchk();
        i_tgcw_reader_model.access(1'b0, TGCW_WORD_PTR, 16'h0000, 1, rdata, hit);
        expect16(rdata, {enS, 8'h00, enS[3] ? intPin : datS[3], enS[2:0] & datS[2:0]});
        expect16({10'h0, comOeN, comOut}, {10'h0, ~enS[2:0], enS[2:0] & datS[2:0]});
    endtask
    task automatic t_all_on();
        #1 intPin = 1'b1;
        wr(16'hf0f5);
        rdchk();
        #1 intPin = 1'b0;
        wr(16'h8088);
        rdchk();
    endtask
    task automatic t_mask();
        wr(16'h7f07);
        rdchk();
        wr(16'h0011);
        rdchk();
        wr(16'h2020);
        rdchk();
    endtask
    task automatic t_test_value();
        wr(16'h0088);
        rdchk();
        wr(16'h0080);
        rdchk();
    endtask
    task automatic t_miss();
        i_tgcw_reader_model.access(1'b1, 16'h9e01, 16'hffff, 0, rdata, hit);
        expect16({15'h0, hit}, 16'h0000);
        i_tgcw_reader_model.access(1'b0, 16'h9e01, 16'h0000, 2, rdata, hit);
        expect16(rdata, 16'h0000);
        rdchk();
    endtask
    task automatic t_low_volt();
        wr(16'hf0f7);
        #1 lowVoltRst = 1'b1;
        @(posedge ref_clk);
        #1 lowVoltRst = 1'b0;
        enS = 4'h0;
        datS = 4'h0;
        rdchk();
    endtask
    task automatic close_out();
        $display("checks %0d failCount %0d", checks, failCount);
        if (failCount == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge ref_clk);
        #1 srst = 1'b0;
        rdchk();
        t_all_on();
        t_mask();
        t_test_value();
        t_miss();
        t_low_volt();
        close_out();
    end
    // Watchdog well beyond the roughly 80 cycles the tests need
    initial begin
        repeat (3000) @(posedge ref_clk);
        failCount++;
        close_out();
    end
endmodule
